// [qsss_pkg.sv]
// constants and types for the correction shadow sync-select register bank
package qsss_pkg;

  // bus geometry
  localparam int unsigned AXI_AW = 10;
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned NGRP   = 4;
  localparam int unsigned FLD_W  = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RSVD_A    = 8'h1c;  // factory_reserved_a
  localparam logic [7:0] IDX_RSVD_B    = 8'h1d;  // factory_reserved_b
  localparam logic [7:0] IDX_SYNC_SEL  = 8'h1e;  // correction_sync_select
  localparam logic [7:0] IDX_SW_SYNC   = 8'h40;  // software sync control
  localparam logic [7:0] IDX_PEND_BASE = 8'h41;  // pending values, one per group
  localparam logic [7:0] IDX_ACT_BASE  = 8'h45;  // active values, read only

  // reset values
  localparam logic [15:0] SYNC_SEL_RST = 16'h1111;
  localparam logic [15:0] RSVD_RST     = 16'h0000;
  localparam logic [15:0] PEND_RST     = 16'h0000;
  localparam logic [15:0] ACT_RST      = 16'h0000;

  // field lsb per group: 0 offset ab, 1 offset cd, 2 gain/phase ab, 3 gain/phase cd
  localparam int unsigned GRP_LSB [NGRP] = '{12, 8, 4, 0};

  // source bit order inside a field
  localparam int unsigned SRC_SW     = 3;
  localparam int unsigned SRC_PIN    = 2;
  localparam int unsigned SRC_STROBE = 1;
  localparam int unsigned SRC_AUTO   = 0;

  // software sync bit position in its control register
  localparam int unsigned SW_SYNC_BIT = 0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus channel states
  typedef enum logic [0:0] {WR_IDLE = 1'h0, WR_RESP = 1'h1} qsss_wr_state_t;
  typedef enum logic [0:0] {RD_IDLE = 1'h0, RD_DATA = 1'h1} qsss_rd_state_t;

endpackage : qsss_pkg

// [qsss_shadow_group.sv]
// one double-buffered correction group: pending value copied to active on an enabled sync
`timescale 1ns/1ns
module qsss_shadow_group (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // source selection and events
  input  wire logic [qsss_pkg::FLD_W-1:0]     sources,
  qsss_sync_if.dst                            evt,
  input  wire logic                           auto_evt,
  // values
  input  wire logic [qsss_pkg::REG_W-1:0]     pending,
  output logic      [qsss_pkg::REG_W-1:0]     active
);

  logic [qsss_pkg::REG_W-1:0] active_r;
  logic [qsss_pkg::REG_W-1:0] active_nxt;
  logic [qsss_pkg::FLD_W-1:0] events;
  logic                       fire;

  // any enabled source copies, sources or-ed together
  always_comb begin
    events                       = '0;
    events[qsss_pkg::SRC_SW]     = evt.sw_evt;
    events[qsss_pkg::SRC_PIN]    = evt.pin_evt;
    events[qsss_pkg::SRC_STROBE] = evt.strobe_evt;
    events[qsss_pkg::SRC_AUTO]   = auto_evt;
    fire                         = |(sources & events);
    active_nxt                   = fire ? pending : active_r;
  end

  // active register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_r <= qsss_pkg::ACT_RST;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign active = active_r;

endmodule : qsss_shadow_group

// [qsss_sync_if.sv]
// sync event bundle shared by the register bank and its shadow groups
`timescale 1ns/1ns
interface qsss_sync_if;
  logic sw_evt;      // software sync rising edge
  logic pin_evt;     // sync pin rising edge
  logic strobe_evt;  // output strobe rising edge

  modport src (output sw_evt, output pin_evt, output strobe_evt);
  modport dst (input sw_evt, input pin_evt, input strobe_evt);
endinterface : qsss_sync_if

// [qsss_sync_select.sv]
// axi4-lite register bank selecting sync sources of the correction shadow registers
// Functional notes
// - bits 15:12 choose offset ab sources: sw, pin, strobe, auto-on-write.
// - bits 11:8 choose offset cd sources in the same order.
// - bits 7:4 choose gain/phase ab sources in the same order.
// - bits 3:0 choose gain/phase cd sources in the same order.
// - set bits enable sources; several may be set; enabled events are or-ed.
// - select register resets to 0x1111, auto sync only for every group.
// - indices 0x1c and 0x1d are factory reserved, held at zero.
`timescale 1ns/1ns
module qsss_sync_select (
  // clock and reset
  input  wire logic                                          aclk,
  input  wire logic                                          aresetn,
  // axi4-lite write address
  input  wire logic [qsss_pkg::AXI_AW-1:0]                   s_axi_awaddr,
  input  wire logic                                          s_axi_awvalid,
  output logic                                               s_axi_awready,
  // axi4-lite write data
  input  wire logic [qsss_pkg::AXI_DW-1:0]                   s_axi_wdata,
  input  wire logic [3:0]                                    s_axi_wstrb,
  input  wire logic                                          s_axi_wvalid,
  output logic                                               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                                         s_axi_bresp,
  output logic                                               s_axi_bvalid,
  input  wire logic                                          s_axi_bready,
  // axi4-lite read
  input  wire logic [qsss_pkg::AXI_AW-1:0]                   s_axi_araddr,
  input  wire logic                                          s_axi_arvalid,
  output logic                                               s_axi_arready,
  output logic [qsss_pkg::AXI_DW-1:0]                        s_axi_rdata,
  output logic [1:0]                                         s_axi_rresp,
  output logic                                               s_axi_rvalid,
  input  wire logic                                          s_axi_rready,
  // sync pins
  input  wire logic                                          sync_in,
  input  wire logic                                          output_strobe_input,
  // active correction values to the data paths
  output logic [qsss_pkg::NGRP-1:0][qsss_pkg::REG_W-1:0]     correction_active
);

  // write channel state
  qsss_pkg::qsss_wr_state_t                 wst_r, wst_nxt;
  logic                                     aw_got_r, aw_got_nxt;
  logic                                     w_got_r, w_got_nxt;
  logic [qsss_pkg::AXI_AW-1:0]              awaddr_r, awaddr_nxt;
  logic [qsss_pkg::AXI_DW-1:0]              wdata_r, wdata_nxt;
  logic [3:0]                               wstrb_r, wstrb_nxt;
  logic [1:0]                               bresp_r, bresp_nxt;
  // register contents
  logic [qsss_pkg::REG_W-1:0]               sync_sel_r, sync_sel_nxt;
  logic                                     sw_sync_r, sw_sync_nxt;
  logic [qsss_pkg::NGRP-1:0][qsss_pkg::REG_W-1:0] pend_r, pend_nxt;
  logic [qsss_pkg::NGRP-1:0]                auto_r, auto_nxt;
  // read channel state
  qsss_pkg::qsss_rd_state_t                 rst_r, rst_nxt;
  logic [qsss_pkg::AXI_DW-1:0]              rdata_r, rdata_nxt;
  logic [1:0]                               rresp_r, rresp_nxt;
  // edge history
  logic                                     sw_prev_r, sync_prev_r, strobe_prev_r;
  // decode helpers
  logic                                     have_aw, have_w;
  logic [qsss_pkg::AXI_AW-1:0]              wa;
  logic [qsss_pkg::AXI_DW-1:0]              wd;
  logic [3:0]                               ws;
  logic [7:0]                               widx, ridx;

  qsss_sync_if sync_bus ();

  // merge byte lanes of a 16-bit register; upper lanes have no storage
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [15:0] res;
    res       = old;
    if (strb[0]) res[7:0]  = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction : lane_merge

  // rising edges become one-cycle events; the pins are taken as synchronous
  assign sync_bus.sw_evt     = sw_sync_r & ~sw_prev_r;
  assign sync_bus.pin_evt    = sync_in & ~sync_prev_r;
  assign sync_bus.strobe_evt = output_strobe_input & ~strobe_prev_r;

  // write channel: address and data taken in either order, then one response
  always_comb begin
    wst_nxt      = wst_r;
    aw_got_nxt   = aw_got_r;
    w_got_nxt    = w_got_r;
    awaddr_nxt   = awaddr_r;
    wdata_nxt    = wdata_r;
    wstrb_nxt    = wstrb_r;
    bresp_nxt    = bresp_r;
    sync_sel_nxt = sync_sel_r;
    sw_sync_nxt  = sw_sync_r;
    pend_nxt     = pend_r;
    auto_nxt     = '0;  // auto events last one cycle, in the same cycle the pending value lands
    s_axi_awready = (wst_r == qsss_pkg::WR_IDLE) && !aw_got_r;
    s_axi_wready  = (wst_r == qsss_pkg::WR_IDLE) && !w_got_r;
    have_aw      = aw_got_r | (s_axi_awvalid & s_axi_awready);
    have_w       = w_got_r | (s_axi_wvalid & s_axi_wready);
    wa           = aw_got_r ? awaddr_r : s_axi_awaddr;
    wd           = w_got_r ? wdata_r : s_axi_wdata;
    ws           = w_got_r ? wstrb_r : s_axi_wstrb;
    widx         = wa[9:2];
    unique case (wst_r)
      qsss_pkg::WR_IDLE: begin
        if (have_aw && have_w) begin
          aw_got_nxt = 1'b0;
          w_got_nxt  = 1'b0;
          wst_nxt    = qsss_pkg::WR_RESP;
          bresp_nxt  = qsss_pkg::RESP_OKAY;
          if (widx == qsss_pkg::IDX_SYNC_SEL) begin
            sync_sel_nxt = lane_merge(sync_sel_r, wd, ws);
          end else if (widx == qsss_pkg::IDX_SW_SYNC) begin
            if (ws[0]) begin
              sw_sync_nxt = wd[qsss_pkg::SW_SYNC_BIT];
            end
          end else if (widx == qsss_pkg::IDX_RSVD_A || widx == qsss_pkg::IDX_RSVD_B) begin
            bresp_nxt = qsss_pkg::RESP_OKAY;  // writes dropped, stays zero
          end else if (widx >= qsss_pkg::IDX_PEND_BASE && widx < qsss_pkg::IDX_ACT_BASE) begin
            for (int g = 0; g < qsss_pkg::NGRP; g++) begin
              if (widx == qsss_pkg::IDX_PEND_BASE + 8'(g)) begin
                pend_nxt[g] = lane_merge(pend_r[g], wd, ws);
                auto_nxt[g] = 1'b1;
              end
            end
          end else if (widx >= qsss_pkg::IDX_ACT_BASE
                       && widx < qsss_pkg::IDX_ACT_BASE + 8'(qsss_pkg::NGRP)) begin
            bresp_nxt = qsss_pkg::RESP_OKAY;  // active values are read only
          end else begin
            bresp_nxt = qsss_pkg::RESP_SLVERR;
          end
        end else begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
          end
        end
      end
      qsss_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          wst_nxt = qsss_pkg::WR_IDLE;
        end
      end
    endcase
  end

  // write side and register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r         <= qsss_pkg::WR_IDLE;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      bresp_r       <= qsss_pkg::RESP_OKAY;
      sync_sel_r    <= qsss_pkg::SYNC_SEL_RST;
      sw_sync_r     <= 1'b0;
      pend_r        <= {qsss_pkg::NGRP{qsss_pkg::PEND_RST}};
      auto_r        <= '0;
      sw_prev_r     <= 1'b0;
      sync_prev_r   <= 1'b0;
      strobe_prev_r <= 1'b0;
    end else begin
      wst_r         <= wst_nxt;
      aw_got_r      <= aw_got_nxt;
      w_got_r       <= w_got_nxt;
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      wstrb_r       <= wstrb_nxt;
      bresp_r       <= bresp_nxt;
      sync_sel_r    <= sync_sel_nxt;
      sw_sync_r     <= sw_sync_nxt;
      pend_r        <= pend_nxt;
      auto_r        <= auto_nxt;
      sw_prev_r     <= sw_sync_r;
      sync_prev_r   <= sync_in;
      strobe_prev_r <= output_strobe_input;
    end
  end

  assign s_axi_bvalid = (wst_r == qsss_pkg::WR_RESP);
  assign s_axi_bresp  = bresp_r;

  // read channel: data registered, answered the cycle after the address is taken
  always_comb begin
    rst_nxt       = rst_r;
    rdata_nxt     = rdata_r;
    rresp_nxt     = rresp_r;
    s_axi_arready = (rst_r == qsss_pkg::RD_IDLE);
    ridx          = s_axi_araddr[9:2];
    unique case (rst_r)
      qsss_pkg::RD_IDLE: begin
        if (s_axi_arvalid) begin
          rst_nxt   = qsss_pkg::RD_DATA;
          rdata_nxt = '0;
          rresp_nxt = qsss_pkg::RESP_OKAY;
          if (ridx == qsss_pkg::IDX_SYNC_SEL) begin
            rdata_nxt[15:0] = sync_sel_r;
          end else if (ridx == qsss_pkg::IDX_RSVD_A || ridx == qsss_pkg::IDX_RSVD_B) begin
            rdata_nxt[15:0] = qsss_pkg::RSVD_RST;
          end else if (ridx == qsss_pkg::IDX_SW_SYNC) begin
            rdata_nxt[qsss_pkg::SW_SYNC_BIT] = sw_sync_r;
          end else if (ridx >= qsss_pkg::IDX_PEND_BASE
                       && ridx < qsss_pkg::IDX_ACT_BASE + 8'(qsss_pkg::NGRP)) begin
            for (int g = 0; g < qsss_pkg::NGRP; g++) begin
              if (ridx == qsss_pkg::IDX_PEND_BASE + 8'(g)) begin
                rdata_nxt[15:0] = pend_r[g];
              end
              if (ridx == qsss_pkg::IDX_ACT_BASE + 8'(g)) begin
                rdata_nxt[15:0] = correction_active[g];
              end
            end
          end else begin
            rresp_nxt = qsss_pkg::RESP_SLVERR;
          end
        end
      end
      qsss_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          rst_nxt = qsss_pkg::RD_IDLE;
        end
      end
    endcase
  end

  // read side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r   <= qsss_pkg::RD_IDLE;
      rdata_r <= '0;
      rresp_r <= qsss_pkg::RESP_OKAY;
    end else begin
      rst_r   <= rst_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_rvalid = (rst_r == qsss_pkg::RD_DATA);
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // one shadow group per four-bit field
  for (genvar g = 0; g < qsss_pkg::NGRP; g++) begin : g_grp
    qsss_shadow_group u_grp (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .sources  (sync_sel_r[qsss_pkg::GRP_LSB[g] +: qsss_pkg::FLD_W]),
      .evt      (sync_bus),
      .auto_evt (auto_r[g]),
      .pending  (pend_r[g]),
      .active   (correction_active[g])
    );
  end

endmodule : qsss_sync_select

// [qsss_sync_select_sva.sv]
// bus handshake and shadow copy checks for the sync-select register bank
`timescale 1ns/1ns
module qsss_sync_select_sva (
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // write side
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  // read side
  input wire logic [9:0]       s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // sync pins and active values
  input wire logic             sync_in,
  input wire logic             output_strobe_input,
  input wire logic [3:0][15:0] correction_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic pin_q;
  logic str_q;
  logic cause_r;

  // any event that may legally move an active value, a cycle late to match the copy
  always_ff @(posedge aclk) begin
    pin_q   <= aresetn & sync_in;
    str_q   <= aresetn & output_strobe_input;
    cause_r <= aresetn & (s_axi_bvalid | (sync_in & ~pin_q) | (output_strobe_input & ~str_q));
  end

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_resp_a: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  rsvd_zero_a: assert property (
    rd_taken ##0 (s_axi_araddr[9:2] == qsss_pkg::IDX_RSVD_A || s_axi_araddr[9:2] == qsss_pkg::IDX_RSVD_B)
    |=> s_axi_rdata == 32'h0000_0000) else $error("reserved register not zero");
  active_cause_a: assert property ($changed(correction_active) |-> cause_r)
    else $error("active value moved without event");

  cover property (wr_taken ##1 s_axi_bvalid);
endmodule : qsss_sync_select_sva

bind qsss_sync_select qsss_sync_select_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sync_in,
  .output_strobe_input, .correction_active);

// [tb_qsss_sync_select.sv]
// self-checking bench for the correction sync-select register bank
`timescale 1ns/1ns
module tb_qsss_sync_select;
  // drives
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [9:0]       s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic [3:0]       s_axi_wstrb = 4'h0;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic             sync_in = 1'b0, output_strobe_input = 1'b0;
  // observed
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic [31:0]      s_axi_rdata;
  logic [3:0][15:0] correction_active;
  // reference model
  int               sel = 32'h1111, sw, pend[4], act[4];
  int               n_fail, cmp_count, seed = 67313;

  qsss_sync_select uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sync_in, .output_strobe_input, .correction_active);

  always #4 aclk = ~aclk;

  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic bit mapped(input logic [7:0] i);
    return i inside {[8'h1c:8'h1e], [8'h40:8'h48]};
  endfunction : mapped

  // copy pending to active for every group that enables source s
  task fire(input int s);
    for (int g = 0; g < 4; g++) if (sel[qsss_pkg::GRP_LSB[g] + s]) act[g] = pend[g];
  endtask : fire

  task wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] st);
    logic [1:0] resp;
    int         k;
    int         m;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= {2'b00, st};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 50) n_fail++;
    chk(resp, mapped(idx) ? qsss_pkg::RESP_OKAY : qsss_pkg::RESP_SLVERR);
    m = (st[0] ? 32'h00ff : 32'h0) | (st[1] ? 32'hff00 : 32'h0);
    if (idx == qsss_pkg::IDX_SYNC_SEL) sel = (sel & ~m) | (d & m);
    if (idx == qsss_pkg::IDX_SW_SYNC && st[0]) begin
      if (d[0] && !sw) fire(qsss_pkg::SRC_SW);
      sw = d[0];
    end
    if (idx inside {[8'h41:8'h44]}) begin
      k = idx - 8'h41;
      pend[k] = (pend[k] & ~m) | (d & m);
      if (sel[qsss_pkg::GRP_LSB[k] + qsss_pkg::SRC_AUTO]) act[k] = pend[k];
    end
  endtask : wr

  task rd(input logic [7:0] idx);
    int k;
    int e;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    s_axi_rready <= 1'b0;
    if (k == 50) n_fail++;
    e = 0;
    if (idx == qsss_pkg::IDX_SYNC_SEL) e = sel;
    if (idx == qsss_pkg::IDX_SW_SYNC) e = sw;
    if (idx inside {[8'h41:8'h44]}) e = pend[idx - 8'h41];
    if (idx inside {[8'h45:8'h48]}) e = act[idx - 8'h45];
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, mapped(idx) ? qsss_pkg::RESP_OKAY : qsss_pkg::RESP_SLVERR);
  endtask : rd

  // one-cycle-wide pin level pulse, rising edge is the event
  task pulse(input int s);
    @(posedge aclk);
    if (s == qsss_pkg::SRC_PIN) sync_in <= 1'b1;
    else output_strobe_input <= 1'b1;
    @(posedge aclk);
    sync_in <= 1'b0;
    output_strobe_input <= 1'b0;
    fire(s);
  endtask : pulse

  // let the copy land, then compare ports and read-back
  task check_act;
    repeat (2) @(posedge aclk);
    for (int g = 0; g < 4; g++) chk(correction_active[g], act[g]);
    for (int g = 0; g < 4; g++) rd(8'h45 + 8'(g));
    for (int g = 0; g < 4; g++) rd(8'h41 + 8'(g));
  endtask : check_act

  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 8'h1c; i <= 8'h1e; i++) rd(8'(i));
    check_act();
    $display("test reset done");
    wr(8'h1c, 16'hffff, 2'b11);
    wr(8'h1d, 16'ha5a5, 2'b11);
    rd(8'h1c);
    rd(8'h1d);
    wr(8'h10, 16'h1234, 2'b11);
    rd(8'h10);
    rd(8'h49);
    // active values are read only: a write must leave them where they are
    wr(8'h45, 16'hbeef, 2'b11);
    check_act();
    $display("test reserved done");
    // one-hot selects walk every field bit, then random mixes exercise the or
    for (int i = 0; i < 24; i++) begin
      wr(qsss_pkg::IDX_SYNC_SEL, i < 16 ? 16'(1 << i) : 16'($random(seed)), 2'b11);
      rd(qsss_pkg::IDX_SYNC_SEL);
      for (int s = 3; s >= 1; s--) begin
        for (int g = 0; g < 4; g++)
          wr(8'h41 + 8'(g), 16'($random(seed)), 2'($unsigned($random(seed)) % 3 + 1));
        check_act();
        if (s == qsss_pkg::SRC_SW) begin
          wr(qsss_pkg::IDX_SW_SYNC, 16'h0001, 2'b01);
          rd(qsss_pkg::IDX_SW_SYNC);
          wr(qsss_pkg::IDX_SW_SYNC, 16'h0000, 2'b01);
        end else pulse(s);
        check_act();
      end
    end
    $display("test sources done");
    // reset in mid-run must bring back the defaults over changed contents
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    sel = 32'h1111;
    sw = 0;
    for (int g = 0; g < 4; g++) begin
      pend[g] = 0;
      act[g] = 0;
    end
    rd(qsss_pkg::IDX_SYNC_SEL);
    rd(qsss_pkg::IDX_SW_SYNC);
    check_act();
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : tb_qsss_sync_select
